// *** hw/dirm_pkg.sv ***
// Purpose: constants for the digital input routing mux
// Assumes: one clock, synchronous reset
// Notes:   selector codes are the routing table's encoding
package dirm_pkg;
  // ---------------------------------------------------------------
  // sizes and reset values
  // ---------------------------------------------------------------
  localparam int          SEL_COUNT    = 36;
  localparam int          CODE_W       = 8;
  localparam int          SUBIDX_W     = 8;
  localparam logic [7:0]  COUNT_VALUE  = 8'h24;
  localparam logic [7:0]  SEL_RESET    = 8'h00;
  localparam logic [7:0]  SUBIDX_COUNT = 8'h00;
  localparam logic [7:0]  SUBIDX_FIRST = 8'h01;
  // ---------------------------------------------------------------
  // selector codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  CODE_ZERO    = 8'h00;
  localparam logic [7:0]  CODE_PIN_LO  = 8'h01;
  localparam logic [7:0]  CODE_PIN_HI  = 8'h10;
  localparam logic [7:0]  CODE_AUX_LO  = 8'h41;
  localparam logic [7:0]  CODE_AUX_HI  = 8'h50;
  localparam logic [7:0]  CODE_ONE     = 8'h80;
  localparam logic [7:0]  CODE_INV     = 8'h80;
endpackage : dirm_pkg

// *** hw/dirm_mux.sv ***
// Purpose: per-bit source selectors building the digital input summary word
// Assumes: object dictionary access arrives as a subindex write/read port on clk
// Notes:   pin-side inputs are synchronised with two flip-flops
module dirm_mux
(
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic [15:0]                    phys_in,
  input  wire logic [2:0]                     hall_in,
  input  wire logic [2:0]                     enc_in,
  input  wire logic                           usb_power_in,
  input  wire logic                           net_active_in,
  input  wire logic [7:0]                     dip_in,
  input  wire logic                           od_wr,
  input  wire logic [7:0]                     od_subidx,
  input  wire logic [7:0]                     od_wdata,
  output logic      [7:0]                     od_rdata,
  output logic                                od_err,
  output logic      [dirm_pkg::SEL_COUNT*8-1:0] sel_pdo,
  output logic      [dirm_pkg::SEL_COUNT-1:0] digital_input_summary_word
);
  localparam int N = dirm_pkg::SEL_COUNT;

  typedef struct packed {
    logic [N*8-1:0] sel;
    logic [31:0]    sync1;
    logic [31:0]    sync2;
    logic [N-1:0]   word;
  } dirm_state_s;

  dirm_state_s s_q;
  dirm_state_s s_d;

  // ---------------------------------------------------------------
  // source decode
  // ---------------------------------------------------------------
  // 16 pins in bits 15:0, aux sources (hall, enc, usb, net, dip) in 31:16
  function automatic logic dirm_route(input logic [7:0] code, input logic [31:0] src);
    logic [6:0] base;
    logic       v;
    base = code[6:0];
    v    = 1'b0;
    if (base == 7'h00)
      v = code[7];
    else if (base >= dirm_pkg::CODE_PIN_LO[6:0] && base <= dirm_pkg::CODE_PIN_HI[6:0])
      v = src[4'(base - 7'h01)] ^ code[7];
    else if (base >= dirm_pkg::CODE_AUX_LO[6:0] && base <= dirm_pkg::CODE_AUX_HI[6:0])
      v = src[5'(5'd16 + 5'(base - dirm_pkg::CODE_AUX_LO[6:0]))] ^ code[7];
    else
      v = 1'b0;
    // codes 51..7f mirror unassigned, also zero; c0 too (base 40)
    return v;
  endfunction : dirm_route

  logic [31:0] raw_src;
  assign raw_src = {dip_in, net_active_in, usb_power_in, enc_in, hall_in, phys_in};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [7:0] idx;
  always_comb
  begin
    idx   = 8'(od_subidx - dirm_pkg::SUBIDX_FIRST);
    s_d   = s_q;
    s_d.sync1 = raw_src;
    s_d.sync2 = s_q.sync1;
    if (od_wr && od_subidx >= dirm_pkg::SUBIDX_FIRST && od_subidx <= dirm_pkg::COUNT_VALUE)
      s_d.sel[idx*8 +: 8] = od_wdata;
    for (int i = 0; i < N; i++)
    begin
      // word uses current selectors, so a write shows one cycle after it lands
      s_d.word[i] = dirm_route(s_q.sel[i*8 +: 8], s_q.sync2);
    end
    if (rst)
    begin
      s_d.sel   = {N{dirm_pkg::SEL_RESET}};
      s_d.sync1 = '0;
      s_d.sync2 = '0;
      s_d.word  = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    s_q <= s_d;
  end

  // ---------------------------------------------------------------
  // read side
  // ---------------------------------------------------------------
  always_comb
  begin
    od_rdata = 8'h00;
    od_err   = 1'b0;
    if (od_subidx == dirm_pkg::SUBIDX_COUNT)
      od_rdata = dirm_pkg::COUNT_VALUE;
    else if (od_subidx <= dirm_pkg::COUNT_VALUE)
      od_rdata = s_q.sel[idx*8 +: 8];
    else
      od_err = 1'b1;
    // the count entry is read-only; a write to it is flagged
    if (od_wr && od_subidx == dirm_pkg::SUBIDX_COUNT)
      od_err = 1'b1;
  end

  assign sel_pdo                    = s_q.sel;
  assign digital_input_summary_word = s_q.word;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  count_fixed_a : assert property (@(posedge clk) disable iff (rst)
    od_subidx == 8'h00 |-> od_rdata == 8'h24)
    else $error("count entry not 24");

  reset_zero_a : assert property (@(posedge clk)
    rst |=> sel_pdo == '0 && digital_input_summary_word == '0)
    else $error("selectors not cleared by reset");

  sequence wr_sel0_s;
    od_wr && od_subidx == 8'h01;
  endsequence

  write_lands_a : assert property (@(posedge clk) disable iff (rst)
    wr_sel0_s |=> sel_pdo[7:0] == $past(od_wdata))
    else $error("selector write lost");

  zero_code_a : assert property (@(posedge clk) disable iff (rst)
    sel_pdo[7:0] == 8'h00 |=> digital_input_summary_word[0] == 1'b0)
    else $error("code 00 not zero");

  one_code_a : assert property (@(posedge clk) disable iff (rst)
    sel_pdo[15:8] == 8'h80 |=> digital_input_summary_word[1] == 1'b1)
    else $error("code 80 not one");

  pin_route_a : assert property (@(posedge clk) disable iff (rst)
    sel_pdo[7:0] == 8'h01 |=> digital_input_summary_word[0] == $past(s_q.sync2[0]))
    else $error("pin 1 not routed");

  hall_inv_a : assert property (@(posedge clk) disable iff (rst)
    sel_pdo[7:0] == 8'hc1 |=> digital_input_summary_word[0] == !$past(s_q.sync2[16]))
    else $error("inverted hall U wrong");

  dip_route_a : assert property (@(posedge clk) disable iff (rst)
    sel_pdo[7:0] == 8'h50 |=> digital_input_summary_word[0] == $past(s_q.sync2[31]))
    else $error("switch 8 not routed");

  enc_route_a : assert property (@(posedge clk) disable iff (rst)
    sel_pdo[7:0] == 8'h46 |=> digital_input_summary_word[0] == $past(s_q.sync2[21]))
    else $error("encoder index not routed");

  bad_code_a : assert property (@(posedge clk) disable iff (rst)
    sel_pdo[7:0] == 8'h20 |=> digital_input_summary_word[0] == 1'b0)
    else $error("unassigned code not zero");

  last_bit_a : assert property (@(posedge clk) disable iff (rst)
    sel_pdo[287:280] == 8'h80 |=> digital_input_summary_word[35])
    else $error("selector 36 not on bit 35");

  // ---------------------------------------------------------------
  // checks on the remaining sources
  // ---------------------------------------------------------------
  usb_route_a : assert property (@(posedge clk) disable iff (rst)
    sel_pdo[287:280] == 8'h47 |=> digital_input_summary_word[35] == $past(s_q.sync2[22]))
    else $error("usb power not routed");

  net_route_a : assert property (@(posedge clk) disable iff (rst)
    sel_pdo[7:0] == 8'h48 |=> digital_input_summary_word[0] == $past(s_q.sync2[23]))
    else $error("network active not routed");

  pin_inv_a : assert property (@(posedge clk) disable iff (rst)
    sel_pdo[287:280] == 8'h8f |=> digital_input_summary_word[35] == !$past(s_q.sync2[14]))
    else $error("inverted pin 15 wrong");

  // an inverted unassigned base must not turn into a constant one
  inv_unused_a : assert property (@(posedge clk) disable iff (rst)
    sel_pdo[287:280] == 8'hd7 |=> !digital_input_summary_word[35])
    else $error("inverted unassigned code not zero");

  // ---------------------------------------------------------------
  // checks on access and latency
  // ---------------------------------------------------------------
  sequence refused_wr_s;
    od_wr && (od_subidx == dirm_pkg::SUBIDX_COUNT || od_subidx > dirm_pkg::COUNT_VALUE);
  endsequence

  refused_wr_a : assert property (@(posedge clk) disable iff (rst)
    refused_wr_s |=> sel_pdo == $past(sel_pdo))
    else $error("refused write changed a selector");

  range_err_a : assert property (@(posedge clk) disable iff (rst)
    refused_wr_s |-> od_err)
    else $error("refused write not flagged");

  sequence one_wr_s;
    od_wr && od_subidx == 8'h02 && od_wdata == dirm_pkg::CODE_ONE;
  endsequence

  // word is one register behind the selectors, so a write acts on the second edge
  write_acts_a : assert property (@(posedge clk) disable iff (rst)
    one_wr_s |=> sel_pdo[15:8] == 8'h80 ##1 digital_input_summary_word[1])
    else $error("written code not acting after two edges");

  sequence pin1_held_s;
    (sel_pdo[7:0] == dirm_pkg::CODE_PIN_LO) [*4];
  endsequence

  // two sync stages plus the word register: a pin change shows three edges later
  pin_delay_a : assert property (@(posedge clk) disable iff (rst)
    pin1_held_s |-> digital_input_summary_word[0] == $past(phys_in[0], 3))
    else $error("pin 1 latency not three edges");
endmodule : dirm_mux

// *** bench/dirm_src_model.sv ***
// Purpose: far-side source model, pins, hall, encoder, usb, network and switches
// Assumes: bench changes pat just after a clock edge
// Notes:   plain static levels; the mux synchronises them itself
module dirm_src_model
(
  input  wire logic [31:0] pat,
  output logic      [15:0] phys_in,
  output logic      [2:0]  hall_in,
  output logic      [2:0]  enc_in,
  output logic             usb_power_in,
  output logic             net_active_in,
  output logic      [7:0]  dip_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // packing order matches the uninverted code order 01..10 then 41..50
  assign {dip_in, net_active_in, usb_power_in, enc_in, hall_in, phys_in} = pat;
endmodule : dirm_src_model

// *** bench/tb_dirm_mux.sv ***
// Purpose: self-checking bench for the digital input routing mux
// Assumes: writes one per two cycles except the two back-to-back refused writes, inputs driven 1 ns after clk rises
// Notes:   every one of the 256 codes is written at least once, unassigned ones too
module tb_dirm_mux;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, od_wr = 0, od_err, usb, net;
  logic [7:0] od_subidx = 8'h00, od_wdata = 8'h00, od_rdata, dip, sel_m[36];
  logic [15:0] phys;
  logic [2:0] hall, enc;
  logic [31:0] pat = 32'h0;
  logic [287:0] sel_pdo;
  logic [35:0] word, word_m;
  int fail_count = 0, n_checks = 0;
  logic [7:0] spot[5] = '{8'h01, 8'hc1, 8'h50, 8'h46, 8'h20};
  always #5 clk = ~clk;
  dirm_src_model i_dirm_src_model (.pat(pat), .phys_in(phys), .hall_in(hall), .enc_in(enc),
    .usb_power_in(usb), .net_active_in(net), .dip_in(dip));
  dirm_mux i_dirm_mux (.clk(clk), .rst(rst), .phys_in(phys), .hall_in(hall), .enc_in(enc),
    .usb_power_in(usb), .net_active_in(net), .dip_in(dip), .od_wr(od_wr),
    .od_subidx(od_subidx), .od_wdata(od_wdata), .od_rdata(od_rdata), .od_err(od_err),
    .sel_pdo(sel_pdo), .digital_input_summary_word(word));
  // ---------------------------------------------------------------
  // reference model and helpers
  // ---------------------------------------------------------------
  function automatic logic sb(logic [7:0] c, logic [31:0] p);
    int b;
    b = c[6:0];
    if (b == 0) return c[7];
    if (b <= 16) return c[7] ^ p[b-1];
    if (b >= 65 && b <= 80) return c[7] ^ p[b-49];
    return 1'b0;
  endfunction : sb
  task automatic chk_b(logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t byte %h exp %h", $time, got, exp);
    end
  endtask : chk_b
  task automatic chk_w(logic [35:0] got, logic [35:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t word %h exp %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic wr(logic [7:0] s, logic [7:0] d);
    @(posedge clk);
    #1 od_wr = 1;
    od_subidx = s;
    od_wdata = d;
    #1 chk_b({7'h0, od_err}, 8'h00);
    @(posedge clk);
    #1 od_wr = 0;
    chk_b(od_rdata, d);
  endtask : wr
  task automatic cmp_all();
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < 36; i++) chk_b(sel_pdo[i*8+:8], sel_m[i]);
    for (int i = 0; i < 36; i++) word_m[i] = sb(sel_m[i], pat);
    chk_w(word, word_m);
  endtask : cmp_all
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(36));
    foreach (sel_m[i]) sel_m[i] = 8'h00;
    repeat (8) @(posedge clk);
    #1 rst = 0;
    chk_b(od_rdata, 8'h24);
    cmp_all();
    for (int c = 0; c < 256; c++)
    begin
      wr(8'(c % 36 + 1), 8'(c));
      sel_m[c % 36] = 8'(c);
      if (c % 36 == 35 || c == 255)
      begin
        pat = $urandom;
        cmp_all();
      end
    end
    for (int r = 0; r < 12; r++)
    begin
      pat = (r < 2) ? {32{r[0]}} : $urandom;
      cmp_all();
    end
    wr(8'h24, 8'h80);
    sel_m[35] = 8'h80;
    @(posedge clk);
    #1 chk_b({7'h0, word[35]}, 8'h01);
    // codes that the sweep leaves on other selectors, so the routing checks fire
    wr(8'h02, 8'h80);
    sel_m[1] = 8'h80;
    foreach (spot[j])
    begin
      wr(8'h01, spot[j]);
      sel_m[0] = spot[j];
      pat = $urandom;
      cmp_all();
    end
    // write strobe held high across both refused writes
    for (int k = 0; k < 2; k++)
    begin
      od_subidx = k ? 8'h25 : 8'h00;
      od_wr = 1;
      od_wdata = 8'h55;
      #1 chk_b({7'h0, od_err}, 8'h01);
      @(posedge clk);
      #1;
    end
    od_wr = 0;
    od_subidx = 8'h00;
    #1 chk_b(od_rdata, 8'h24);
    cmp_all();
    // second reset with selectors loaded
    @(posedge clk);
    #1 rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    foreach (sel_m[i]) sel_m[i] = 8'h00;
    od_subidx = 8'h24;
    #1 chk_b(od_rdata, 8'h00);
    cmp_all();
    close_out();
  end
endmodule : tb_dirm_mux
